/* hw/mfg_map.svh */
// offsets, field positions, reset values and timing counts of the gpi control block
`ifndef MFG_MAP_SVH
`define MFG_MAP_SVH

// register offsets (5-bit word address)
`define MFG_OFF_FUNC      5'h00
`define MFG_OFF_EN        5'h01
`define MFG_OFF_LP        5'h02
`define MFG_OFF_RAMP      5'h03
`define MFG_OFF_STAT      5'h04
`define MFG_OFF_MASK      5'h05
`define MFG_OFF_STATE     5'h06
`define MFG_OFF_PGEN      5'h07
// groups of four, one word per master, selected by addr[4:2]
`define MFG_GRP_NORM      3'h2
`define MFG_GRP_DEF       3'h3
`define MFG_GRP_SLP       3'h4
`define MFG_GRP_DLY       3'h5
`define MFG_GRP_CUR       3'h6

// field positions
`define MFG_FUNC0_LSB     0
`define MFG_FUNC1_LSB     4
`define MFG_RU_LSB        0
`define MFG_RD_LSB        4

// function codes of an input
`define MFG_FN_ALL_EN     4'h0
`define MFG_FN_EN_BASE    4'h1
`define MFG_FN_ALL_VSEL   4'h5
`define MFG_FN_VSEL_BASE  4'h6
`define MFG_FN_ALL_LP     4'ha
`define MFG_FN_LP_BASE    4'hb
`define MFG_FN_NONE       4'hf

// reset values
`define MFG_FUNC_RST      8'hff
`define MFG_EN_RST        4'h0
`define MFG_LP_RST        4'h0
`define MFG_RAMP_RST      8'h22
`define MFG_STAT_RST      4'h0
`define MFG_MASK_RST      4'h0
`define MFG_VNORM_RST     8'h50
`define MFG_VDEF_RST      8'h50
`define MFG_VSLP_RST      8'h32
`define MFG_DLY_RST       8'h00

// timing, in ns
`define MFG_CLK_PERIOD_NS 50
`define MFG_STEP0_NS      4000
`define MFG_STEP1_NS      2000
`define MFG_STEP2_NS      1000
`define MFG_STEP3_NS      500
`define MFG_STEP4_NS      250
`define MFG_STEP5_NS      125
`define MFG_STEP6_NS      83
`define MFG_SEQ_UNIT_NS   1000

`endif

/* hw/mfg_pkg.sv */
// types shared by the gpi control block
package mfg_pkg;

   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } mfg_bus_req_t;

   // control bundle handed to one regulator master
   typedef struct packed {
      logic       en;
      logic       low_power;
      logic       pgood_en;
      logic [7:0] vout;
   } mfg_master_ctl_t;

   // ramp progress of one master
   typedef enum logic [1:0] {
      MFG_RAMP_IDLE,
      MFG_RAMP_UP,
      MFG_RAMP_DOWN
   } mfg_ramp_t;

endpackage

/* hw/mfg_gpi_ctrl.sv */
// multifunction general-input decode, enable sequencing, voltage ramp and power-fail flags
`timescale 1ns/1ns
`default_nettype none
`include "mfg_map.svh"

// What this block does
// - two inputs, each with live 4-bit function code
// - code 0: global enable, masters sequenced by delays
// - codes 1-4: per-master enable ORed with bit
// - both inputs same enable code: both ORed
// - code 5: global select default/sleep voltage
// - codes 6-9: per-master voltage select
// - both inputs same select code: ORed
// - voltage steps at ramp-up/ramp-down rate
// - code 10: all masters low power together
// - codes 11-14: per-master low power, ORed
// - code 15: input has no effect
// - phase pins decide which masters exist
// - power-good active: enabled, soft-started, not low-power
// - power-fail flag clears to 0, sets below threshold while power good is active
// - independent low-power bit per master
// - no select applies: normal voltage register used
module mfg_gpi_ctrl #(
   parameter int NUM_MASTERS = 4
) (
   // clock and reset
   input  wire logic                                      mclk,
   input  wire logic                                      reset_n,
   // register port
   input  wire mfg_pkg::mfg_bus_req_t                     bus_req,
   output logic [7:0]                                     bus_rdata,
   // asynchronous pins from the host and straps
   input  wire logic                                      general_input_zero,
   input  wire logic                                      general_input_one,
   input  wire logic                                      phase_config_pin_zero,
   input  wire logic                                      phase_config_pin_one,
   input  wire logic                                      phase_config_pin_two,
   // analog status per master
   input  wire logic [NUM_MASTERS-1:0]                    soft_start_done,
   input  wire logic [NUM_MASTERS-1:0]                    output_below_thr,
   // controls to the regulators
   output mfg_pkg::mfg_master_ctl_t [NUM_MASTERS-1:0]     master_ctl,
   output logic                                           irq
);
   import mfg_pkg::*;

   localparam int NM = NUM_MASTERS;
   localparam int SW = 2 + 3 + 2 * NM;

   // ramp step periods in cycles, never below one
   localparam int STEP0_CYC = `MFG_STEP0_NS / `MFG_CLK_PERIOD_NS;
   localparam int STEP1_CYC = `MFG_STEP1_NS / `MFG_CLK_PERIOD_NS;
   localparam int STEP2_CYC = `MFG_STEP2_NS / `MFG_CLK_PERIOD_NS;
   localparam int STEP3_CYC = `MFG_STEP3_NS / `MFG_CLK_PERIOD_NS;
   localparam int STEP4_CYC = `MFG_STEP4_NS / `MFG_CLK_PERIOD_NS;
   localparam int STEP5_CYC = `MFG_STEP5_NS / `MFG_CLK_PERIOD_NS;
   localparam int STEP6_RAW = `MFG_STEP6_NS / `MFG_CLK_PERIOD_NS;
   localparam int STEP6_CYC = (STEP6_RAW < 1) ? 1 : STEP6_RAW;
   localparam int SEQ_UNIT_CYC = `MFG_SEQ_UNIT_NS / `MFG_CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // synchroniser: the first stage is read only by the second
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic [SW-1:0] pins_raw;
   logic [1:0]    gin_s;
   logic [2:0]    phase_s;
   logic [NM-1:0] ss_done_s;
   logic [NM-1:0] below_s;

   assign pins_raw = {output_below_thr, soft_start_done, phase_config_pin_two,
                      phase_config_pin_one, phase_config_pin_zero,
                      general_input_one, general_input_zero};

   // two flops on every pin that comes from outside mclk
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   assign gin_s     = sync2_q[1:0];
   assign phase_s   = sync2_q[4:2];
   assign ss_done_s = sync2_q[5 +: NM];
   assign below_s   = sync2_q[5 + NM +: NM];

   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   logic [7:0]    func_q;
   logic [NM-1:0] en_bits_q;
   logic [NM-1:0] lp_bits_q;
   logic [7:0]    ramp_q;
   logic [NM-1:0] stat_q;
   logic [NM-1:0] mask_q;
   logic [7:0]    vnorm_q [NM];
   logic [7:0]    vdef_q  [NM];
   logic [7:0]    vslp_q  [NM];
   logic [7:0]    dly_q   [NM];
   logic [7:0]    cur_q   [NM];
   logic [2:0]    grp;
   logic [1:0]    idx;

   assign grp = bus_req.addr[4:2];
   assign idx = bus_req.addr[1:0];

   // plain control registers; the function code takes effect the next cycle
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         func_q    <= `MFG_FUNC_RST;
         en_bits_q <= `MFG_EN_RST;
         lp_bits_q <= `MFG_LP_RST;
         ramp_q    <= `MFG_RAMP_RST;
         mask_q    <= `MFG_MASK_RST;
      end
      else if (bus_req.wr)
      begin
         case (bus_req.addr)
            `MFG_OFF_FUNC: func_q    <= bus_req.wdata;
            `MFG_OFF_EN:   en_bits_q <= bus_req.wdata[NM-1:0];
            `MFG_OFF_LP:   lp_bits_q <= bus_req.wdata[NM-1:0];
            `MFG_OFF_RAMP: ramp_q    <= bus_req.wdata;
            `MFG_OFF_MASK: mask_q    <= bus_req.wdata[NM-1:0];
            default:       ;
         endcase
      end
   end

   // per-master voltage and delay words
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         for (int m = 0; m < NM; m++)
         begin
            vnorm_q[m] <= `MFG_VNORM_RST;
            vdef_q[m]  <= `MFG_VDEF_RST;
            vslp_q[m]  <= `MFG_VSLP_RST;
            dly_q[m]   <= `MFG_DLY_RST;
         end
      end
      else if (bus_req.wr && (32'(idx) < NM))
      begin
         case (grp)
            `MFG_GRP_NORM: vnorm_q[idx] <= bus_req.wdata;
            `MFG_GRP_DEF:  vdef_q[idx]  <= bus_req.wdata;
            `MFG_GRP_SLP:  vslp_q[idx]  <= bus_req.wdata;
            `MFG_GRP_DLY:  dly_q[idx]   <= bus_req.wdata;
            default:       ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // masters present for the strapped phase layout
   logic [NM-1:0] present;

   always_comb
   begin
      present = '0;
      case (phase_s)
         3'h0:    present = NM'(4'hf);
         3'h1:    present = NM'(4'h7);
         3'h2:    present = NM'(4'h7);
         3'h3:    present = NM'(4'h3);
         default: present = NM'(4'h1);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decode of both inputs; matching inputs simply OR together
   logic          global_enable_function_lvl;
   logic [NM-1:0] en_pin;
   logic [NM-1:0] vs_app;
   logic [NM-1:0] vs_lvl;
   logic [NM-1:0] lp_pin;

   always_comb
   begin
      logic [3:0] code;
      code       = '0;
      global_enable_function_lvl = 1'b0;
      en_pin     = '0;
      vs_app     = '0;
      vs_lvl     = '0;
      lp_pin     = '0;
      for (int i = 0; i < 2; i++)
      begin
         code = func_q[i*4 +: 4];
         // code 15 matches nothing below, so the input is ignored
         if (code == `MFG_FN_ALL_EN)
            global_enable_function_lvl = global_enable_function_lvl | gin_s[i];
         for (int m = 0; m < NM; m++)
         begin
            if (code == `MFG_FN_EN_BASE + 4'(m))
               en_pin[m] = en_pin[m] | gin_s[i];
            if (code == `MFG_FN_ALL_VSEL || code == `MFG_FN_VSEL_BASE + 4'(m))
            begin
               vs_app[m] = 1'b1;
               vs_lvl[m] = vs_lvl[m] | gin_s[i];
            end
            if (code == `MFG_FN_ALL_LP || code == `MFG_FN_LP_BASE + 4'(m))
               lp_pin[m] = lp_pin[m] | gin_s[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // global enable sequencer: a time base in delay units since assertion
   logic [15:0]   unit_cnt_q;
   logic [7:0]    seq_units_q;
   logic [NM-1:0] seq_on;

   always_ff @(posedge mclk)
   begin
      if (!reset_n || !global_enable_function_lvl)
      begin
         unit_cnt_q  <= '0;
         seq_units_q <= '0;
      end
      else if (unit_cnt_q == 16'(SEQ_UNIT_CYC - 1))
      begin
         unit_cnt_q <= '0;
         // saturate so a long assertion never wraps masters back off
         if (seq_units_q != 8'hff)
            seq_units_q <= seq_units_q + 8'h01;
      end
      else
         unit_cnt_q <= unit_cnt_q + 16'h0001;
   end

   always_comb
   begin
      for (int m = 0; m < NM; m++)
         seq_on[m] = global_enable_function_lvl && (seq_units_q >= dly_q[m]);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // effective per-master controls
   logic [NM-1:0] en_eff;
   logic [NM-1:0] lp_eff;
   logic [NM-1:0] pg_en;
   logic [7:0]    tgt [NM];

   always_comb
   begin
      for (int m = 0; m < NM; m++)
      begin
         en_eff[m] = present[m] & (en_bits_q[m] | en_pin[m] | seq_on[m]);
         lp_eff[m] = present[m] & (lp_bits_q[m] | lp_pin[m]);
         pg_en[m]  = en_eff[m] & ss_done_s[m] & ~lp_eff[m];
         if (!vs_app[m])
            tgt[m] = vnorm_q[m];
         else if (vs_lvl[m])
            tgt[m] = vdef_q[m];
         else
            tgt[m] = vslp_q[m];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // voltage ramp, one 5 mV code step per rate period
   function automatic logic [7:0] step_cycles(input logic [2:0] rate);
      case (rate)
         3'h0:    step_cycles = 8'(STEP0_CYC);
         3'h1:    step_cycles = 8'(STEP1_CYC);
         3'h2:    step_cycles = 8'(STEP2_CYC);
         3'h3:    step_cycles = 8'(STEP3_CYC);
         3'h4:    step_cycles = 8'(STEP4_CYC);
         3'h5:    step_cycles = 8'(STEP5_CYC);
         default: step_cycles = 8'(STEP6_CYC);
      endcase
   endfunction

   for (genvar gm = 0; gm < NM; gm++)
   begin : g_ramp
      logic [7:0] tick_q;
      logic       rising;
      logic [7:0] period;

      assign rising = tgt[gm] > cur_q[gm];
      assign period = rising ? step_cycles(ramp_q[`MFG_RU_LSB +: 3])
                             : step_cycles(ramp_q[`MFG_RD_LSB +: 3]);

      // the rate is re-read every step, so a rate change acts mid-ramp
      always_ff @(posedge mclk)
      begin
         if (!reset_n)
         begin
            cur_q[gm]   <= `MFG_VNORM_RST;
            tick_q      <= '0;
         end
         else if (cur_q[gm] == tgt[gm])
         begin
            tick_q      <= '0;
         end
         else if (tick_q >= period - 8'h01)
         begin
            tick_q      <= '0;
            cur_q[gm]   <= rising ? cur_q[gm] + 8'h01 : cur_q[gm] - 8'h01;
         end
         else
            tick_q <= tick_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power-fail flags: sticky, write one to clear, a new event beats the clear
   logic [NM-1:0] fail_evt;
   logic [NM-1:0] w1c;

   assign fail_evt = below_s & pg_en;
   assign w1c      = (bus_req.wr && bus_req.addr == `MFG_OFF_STAT) ?
                     bus_req.wdata[NM-1:0] : '0;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         stat_q <= `MFG_STAT_RST;
      else
         stat_q <= (stat_q & ~w1c) | fail_evt;
   end

   // level interrupt while any unmasked flag stands
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         irq <= 1'b0;
      else
         irq <= |((stat_q & ~w1c | fail_evt) & mask_q);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered controls to the regulators
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         for (int m = 0; m < NM; m++)
            master_ctl[m] <= {3'h0, `MFG_VNORM_RST};   // no false ramp step after reset
      else
      begin
         for (int m = 0; m < NM; m++)
         begin
            master_ctl[m].en        <= en_eff[m];
            master_ctl[m].low_power <= lp_eff[m];
            master_ctl[m].pgood_en  <= pg_en[m];
            master_ctl[m].vout      <= cur_q[m];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, valid the cycle after the strobe only; unmapped reads zero
   always_ff @(posedge mclk)
   begin
      if (!reset_n || !bus_req.rd)
         bus_rdata <= '0;
      else if (grp >= `MFG_GRP_NORM && grp <= `MFG_GRP_CUR)
      begin
         if (32'(idx) >= NM)
            bus_rdata <= '0;
         else
         begin
            case (grp)
               `MFG_GRP_NORM: bus_rdata <= vnorm_q[idx];
               `MFG_GRP_DEF:  bus_rdata <= vdef_q[idx];
               `MFG_GRP_SLP:  bus_rdata <= vslp_q[idx];
               `MFG_GRP_DLY:  bus_rdata <= dly_q[idx];
               default:       bus_rdata <= cur_q[idx];
            endcase
         end
      end
      else
      begin
         case (bus_req.addr)
            `MFG_OFF_FUNC:  bus_rdata <= func_q;
            `MFG_OFF_EN:    bus_rdata <= 8'(en_bits_q);
            `MFG_OFF_LP:    bus_rdata <= 8'(lp_bits_q);
            `MFG_OFF_RAMP:  bus_rdata <= ramp_q & 8'h77;
            `MFG_OFF_STAT:  bus_rdata <= 8'(stat_q);
            `MFG_OFF_MASK:  bus_rdata <= 8'(mask_q);
            `MFG_OFF_STATE: bus_rdata <= {4'(lp_eff), 4'(en_eff)};
            `MFG_OFF_PGEN:  bus_rdata <= 8'(pg_en);
            default:        bus_rdata <= '0;
         endcase
      end
   end

endmodule // mfg_gpi_ctrl

`default_nettype wire

/* verif/mfg_gpi_ctrl_asserts.sv */
// port-level checks of the gpi control block, bound onto its top module
`timescale 1ns/1ns
`default_nettype none
`include "mfg_map.svh"
module mfg_gpi_ctrl_asserts #(
   parameter int NUM_MASTERS = 4
) (
   // clock and reset
   input wire logic                                  mclk,
   input wire logic                                  reset_n,
   // register port
   input wire mfg_pkg::mfg_bus_req_t                 bus_req,
   input wire logic [7:0]                            bus_rdata,
   // pins
   input wire logic                                  general_input_zero,
   input wire logic                                  general_input_one,
   input wire logic                                  phase_config_pin_zero,
   input wire logic                                  phase_config_pin_one,
   input wire logic                                  phase_config_pin_two,
   // block outputs
   input wire mfg_pkg::mfg_master_ctl_t [NUM_MASTERS-1:0] master_ctl,
   input wire logic                                  irq
);
   import mfg_pkg::*;
   default clocking dcb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [7:0] fn_q;
   logic [3:0] en_q;
   logic [3:0] lp_q;
   logic [3:0] mask_q;
   logic [2:0] quiet_q;
   logic [2:0] solo_q;
   wire logic  quiet = (quiet_q > 3'd4);
   ////////////////////////////////////////////////////////////
   // shadow of the written codes and bits, so checks know what is live
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         fn_q   <= 8'hff;
         en_q   <= 4'h0;
         lp_q   <= 4'h0;
         mask_q <= 4'h0;
      end
      else if (bus_req.wr)
      begin
         case (bus_req.addr)
            `MFG_OFF_FUNC: fn_q   <= bus_req.wdata;
            `MFG_OFF_EN:   en_q   <= bus_req.wdata[3:0];
            `MFG_OFF_LP:   lp_q   <= bus_req.wdata[3:0];
            `MFG_OFF_MASK: mask_q <= bus_req.wdata[3:0];
            default:       ;
         endcase
      end
   end
   // settle count: a write to the code, enable or low-power register needs sync plus decode first; any strap pin high holds it at zero
   always_ff @(posedge mclk)
   begin
      if (!reset_n || (bus_req.wr && bus_req.addr < 5'h03) || phase_config_pin_zero
          || phase_config_pin_one || phase_config_pin_two)
         quiet_q <= 3'd0;
      else if (quiet_q != 3'd7)
         quiet_q <= quiet_q + 3'd1;
   end
   // cycles the strap for a lone master has been held
   always_ff @(posedge mclk)
   begin
      if (!reset_n || !phase_config_pin_two)
         solo_q <= 3'd0;
      else if (solo_q != 3'd7)
         solo_q <= solo_q + 3'd1;
   end
   ////////////////////////////////////////////////////////////
   // assertions
   en_follow_a:
      assert property (quiet && fn_q == 8'hf1 && !en_q[0]
         |-> master_ctl[0].en == $past(general_input_zero, 3))
      else $error("master one enable does not follow input zero");
   en_pair_a:
      assert property (quiet && fn_q == 8'h22 && !en_q[1] |-> master_ctl[1].en
         == ($past(general_input_zero, 3) | $past(general_input_one, 3)))
      else $error("paired enable is not the or of both inputs");
   lp_global_a:
      assert property (quiet && fn_q == 8'hfa && lp_q == 4'h0
         |-> master_ctl[3].low_power == $past(general_input_zero, 3))
      else $error("global low power does not reach master four");
   input_off_a:
      assert property (quiet && fn_q == 8'hff && en_q == 4'h0 && lp_q == 4'h0
         |-> !master_ctl[0].en && !master_ctl[0].low_power)
      else $error("disconnected input still has an effect");
   pgood_gate_a:
      assert property (master_ctl[0].pgood_en |-> master_ctl[0].en && !master_ctl[0].low_power)
      else $error("power good active while off or in low power");
   rdata_idle_a:
      assert property (!bus_req.rd |=> bus_rdata == 8'h00)
      else $error("read data present without a read");
   irq_mask_a:
      assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
      else $error("interrupt raised while fully masked");
   solo_strap_a:
      assert property (solo_q > 3'd4 |-> !master_ctl[1].en && !master_ctl[3].en)
      else $error("absent master enabled");
   ramp_step_a:
      assert property (master_ctl[0].vout == $past(master_ctl[0].vout)
         || master_ctl[0].vout == $past(master_ctl[0].vout) + 8'h01
         || master_ctl[0].vout == $past(master_ctl[0].vout) - 8'h01)
      else $error("voltage code jumped more than one step");
   // main scenarios reached
   cover property (master_ctl[0].pgood_en);
   cover property (irq);
   cover property (master_ctl[0].en && master_ctl[3].en);
endmodule // mfg_gpi_ctrl_asserts

bind mfg_gpi_ctrl mfg_gpi_ctrl_asserts #(.NUM_MASTERS(NUM_MASTERS)) chk_u (.mclk, .reset_n,
   .bus_req, .bus_rdata, .general_input_zero, .general_input_one, .phase_config_pin_zero,
   .phase_config_pin_one, .phase_config_pin_two, .master_ctl, .irq);
`default_nettype wire

/* verif/mfg_host_model.sv */
// host processor model driving the two general inputs
`timescale 1ns/1ns
`default_nettype none
module mfg_host_model #(
   parameter int SKEW_NS = 17
) (
   // levels the bench asks for
   input  wire logic [1:0] level_req,
   // pins toward the block
   output var logic        general_input_zero,
   output var logic        general_input_one
);
   // pins idle low until the host first moves them
   initial {general_input_one, general_input_zero} = 2'b00;
   // host runs off its own clock: edges land at a skew, never on mclk
   always @(level_req) {general_input_one, general_input_zero} <= #(SKEW_NS) level_req;
endmodule // mfg_host_model
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the gpi control block
`timescale 1ns/1ns
`default_nettype none
`include "mfg_map.svh"
module tb;
   import mfg_pkg::*;
   logic                  mclk;
   logic                  reset_n;
   mfg_bus_req_t          req;
   logic [7:0]            rdata;
   logic [1:0]            lvl;
   wire logic             gi0;
   wire logic             gi1;
   logic [2:0]            ph;
   logic [3:0]            ssd;
   logic [3:0]            below;
   mfg_master_ctl_t [3:0] ctl;
   logic                  irq;
   logic [3:0]            en_v;
   logic [3:0]            lp_v;
   logic [3:0]            pg_v;
   int                    fails;
   int                    checked;
   ////////////////////////////////////////////////////////////
   // block and host
   mfg_gpi_ctrl #(.NUM_MASTERS(4)) dut_u (.mclk (mclk), .reset_n (reset_n), .bus_req (req),
      .bus_rdata (rdata), .general_input_zero (gi0), .general_input_one (gi1),
      .phase_config_pin_zero (ph[0]), .phase_config_pin_one (ph[1]),
      .phase_config_pin_two (ph[2]), .soft_start_done (ssd), .output_below_thr (below),
      .master_ctl (ctl), .irq (irq));
   mfg_host_model host_u (.level_req (lvl), .general_input_zero (gi0), .general_input_one (gi1));
   // 20 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // per-master flags gathered into vectors
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         en_v[i] = ctl[i].en;
         lp_v[i] = ctl[i].low_power;
         pg_v[i] = ctl[i].pgood_en;
      end
   end
   ////////////////////////////////////////////////////////////
   // compare, bus cycles and waits
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      req <= '0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string name);
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      req <= '0;
      #1 chk(name, rdata, exp);
   endtask
   // bounded wait for a ramp to land; running out counts as a mismatch
   task automatic wait_vout(input int k, input logic [7:0] exp, input int lim);
      int n;
      n = 0;
      while (ctl[k].vout !== exp && n < lim)
      begin
         tick(1);
         n++;
      end
      chk("vout", ctl[k].vout, exp);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      reset_n = 1'b0;
      req = '0;
      lvl = 2'b00;
      ph = 3'b000;
      ssd = 4'h0;
      below = 4'h0;
      fails = 0;
      checked = 0;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      rd(`MFG_OFF_FUNC, 8'hff, "func");
      rd(5'h1c, 8'h00, "unmapped");
      chk("vout_rst", ctl[0].vout, 8'h50);
      // every per-master enable code, codes rewritten live
      for (int k = 0; k < 4; k++)
      begin
         wr(`MFG_OFF_FUNC, {4'hf, 4'(k + 1)});
         @(posedge mclk) lvl <= 2'b01;
         tick(6);
         chk("en_code", {4'h0, en_v}, 8'(1 << k));
         @(posedge mclk) lvl <= 2'b00;
         tick(6);
         chk("en_off", {4'h0, en_v}, 8'h00);
      end
      // global and per-master low power codes
      for (int c = 10; c < 15; c++)
      begin
         wr(`MFG_OFF_FUNC, {4'hf, 4'(c)});
         @(posedge mclk) lvl <= 2'b01;
         tick(6);
         chk("lp_code", {4'h0, lp_v}, (c == 10) ? 8'h0f : 8'(1 << (c - 11)));
         @(posedge mclk) lvl <= 2'b00;
      end
      // both inputs on one enable code, ored with a register bit, then cut off
      wr(`MFG_OFF_EN, 8'h04);
      wr(`MFG_OFF_FUNC, 8'h22);
      @(posedge mclk) lvl <= 2'b10;
      tick(6);
      chk("en_pair", {4'h0, en_v}, 8'h06);
      wr(`MFG_OFF_EN, 8'h00);
      wr(`MFG_OFF_FUNC, 8'hff);
      @(posedge mclk) lvl <= 2'b11;
      tick(6);
      chk("en_none", {lp_v, en_v}, 8'h00);
      @(posedge mclk) lvl <= 2'b00;
      // global enable: startup delays of 0..3 units stagger the masters
      for (int k = 0; k < 4; k++)
         wr({`MFG_GRP_DLY, 2'(k)}, 8'(k));
      wr(`MFG_OFF_FUNC, 8'hf0);
      @(posedge mclk) lvl <= 2'b01;
      for (int k = 0; k < 4; k++)
      begin
         tick(k == 0 ? 10 : 20);
         chk("seq", {4'h0, en_v}, 8'((2 << k) - 1));
      end
      @(posedge mclk) lvl <= 2'b00;
      tick(6);
      chk("seq_off", {4'h0, en_v}, 8'h00);
      // voltage select: global, per master with both inputs, slow and fast ramps
      wr(`MFG_OFF_RAMP, 8'h66);
      wr({`MFG_GRP_DEF, 2'd0}, 8'h54);
      wr({`MFG_GRP_SLP, 2'd0}, 8'h4c);
      wr(`MFG_OFF_FUNC, 8'hf5);
      wait_vout(0, 8'h4c, 60);
      wait_vout(3, 8'h32, 80);
      @(posedge mclk) lvl <= 2'b01;
      wait_vout(0, 8'h54, 60);
      wait_vout(3, 8'h50, 80);
      wr(`MFG_OFF_FUNC, 8'h66);
      @(posedge mclk) lvl <= 2'b10;
      tick(8);
      chk("vsel_pair", ctl[0].vout, 8'h54);
      chk("vsel_other", ctl[1].vout, 8'h50);
      @(posedge mclk) lvl <= 2'b00;
      for (int k = 1; k < 4; k++)
      begin
         wr(`MFG_OFF_FUNC, {4'hf, 4'(6 + k)});
         wait_vout(k, 8'h32, 60);
      end
      wr(`MFG_OFF_FUNC, 8'h66);
      wait_vout(0, 8'h4c, 60);
      wr(`MFG_OFF_RAMP, 8'h60);
      @(posedge mclk) lvl <= 2'b10;
      tick(100);
      chk("ramp_slow", {7'h0, ctl[0].vout inside {8'h4d, 8'h4e}}, 8'h01);
      wait_vout(0, 8'h54, 800);
      @(posedge mclk) lvl <= 2'b00;
      wait_vout(0, 8'h4c, 20);
      wr(`MFG_OFF_FUNC, 8'hff);
      wait_vout(0, 8'h50, 400);
      // power good, fail flag only on an enabled master, mask and clear
      @(posedge mclk) ssd <= 4'hf;
      wr(`MFG_OFF_EN, 8'h01);
      tick(6);
      chk("pgood", {4'h0, pg_v}, 8'h01);
      rd(`MFG_OFF_STAT, 8'h00, "stat_rst");
      wr(`MFG_OFF_LP, 8'h01);
      tick(4);
      chk("pgood_lp", {4'h0, pg_v}, 8'h00);
      wr(`MFG_OFF_LP, 8'h00);
      @(posedge mclk) below <= 4'h3;
      tick(6);
      rd(`MFG_OFF_STAT, 8'h01, "stat");
      chk("irq_masked", {7'h0, irq}, 8'h00);
      wr(`MFG_OFF_MASK, 8'h01);
      tick(2);
      chk("irq", {7'h0, irq}, 8'h01);
      @(posedge mclk) below <= 4'h0;
      tick(6);
      wr(`MFG_OFF_STAT, 8'h01);
      tick(2);
      rd(`MFG_OFF_STAT, 8'h00, "stat_clr");
      chk("irq_clr", {7'h0, irq}, 8'h00);
      // strap for a lone master hides masters two to four
      wr(`MFG_OFF_EN, 8'h0f);
      @(posedge mclk) ph <= 3'b100;
      tick(6);
      chk("solo", {4'h0, en_v}, 8'h01);
      @(posedge mclk) ph <= 3'b000;
      tick(6);
      chk("all", {4'h0, en_v}, 8'h0f);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
